// ### rtl/crpuc_pkg.sv
// Purpose: constants for the core regulator power-up control block
// Assumes: single 100 MHz clock, active-low asynchronous reset
// Notes: no software registers; all controls are pins
package crpuc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam logic RST_RTC_LATCH = 1'h0;
  localparam logic RST_REG_EN = 1'h0;
  localparam logic RST_POWER_GOOD = 1'h0;
  localparam logic RST_PU_OUT = 1'h0;
  localparam logic RST_SYNC = 1'h0;
  localparam logic RST_INIT_DONE = 1'h0;
  localparam logic RST_INIT_STATE = 1'h0;
  // Pull-up level of the power-up pin when floating
  localparam logic PIN_PULL_LEVEL = 1'h1;
  // Cycles spent in the settle phase; power is reported good 5 cycles after the enable rises
  localparam int unsigned POWER_GOOD_DELAY_CYC = 4;
  localparam int unsigned CNT_W = 3;
endpackage

// ### rtl/crpuc_edge_latch.sv
// Purpose: latch a rising edge of the rtc wake match input
// Assumes: input synchronous to i_clk
// Notes: latch cleared only by reset or by i_clear
`timescale 1ns/100ps
module crpuc_edge_latch (
  input wire logic i_clk,    // System clock
  input wire logic i_rst_b,  // Async reset, active low
  input wire logic i_level,  // Level to watch
  input wire logic i_clear,  // Drop the latched edge
  output logic o_seen        // Rising edge latched
);
  typedef struct packed {
    logic prev;
    logic seen;
  } crpuc_el_t;

  crpuc_el_t st_q;
  crpuc_el_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.prev = i_level;
    if (i_clear) begin
      st_d.seen = 1'h0;
    end
    if (i_level && !st_q.prev) begin
      st_d.seen = 1'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q <= '{prev: crpuc_pkg::RST_SYNC, seen: crpuc_pkg::RST_RTC_LATCH};
    end else begin
      st_q <= st_d;
    end
  end

  assign o_seen = st_q.seen;
endmodule

// ### rtl/crpuc_top.sv
// Purpose: decide whether the core regulator is enabled and report power good
// Assumes: inputs synchronous to i_clk; i_rst_b marks the 3.3 V supply ramp
// Notes: regulator enable is registered, one cycle behind pin, request and test reset, two behind the rtc match
`timescale 1ns/100ps
module crpuc_top #(
  parameter logic REGULATOR_INITIAL_STATE = 1'h0,
  parameter int unsigned PG_DELAY = crpuc_pkg::POWER_GOOD_DELAY_CYC
) (
  input wire logic i_clk,                         // System clock
  input wire logic i_rst_b,                       // Async reset, active low
  input wire logic i_core_power_up_request,       // Core request, 1 enables
  input wire logic i_power_up_pin_n,              // Pad level, active low
  input wire logic i_power_up_pin_n_driven,       // Pad actively driven
  input wire logic i_test_reset,                  // JTAG test reset pin
  input wire logic i_rtc_wake_match,              // Match from real-time clock
  output logic o_regulator_enable,                // Regulator on
  output logic o_core_power_good,                 // Core powered and working
  output logic o_core_power_up_out                // Inverse of power-up pin
);
  localparam int unsigned CW = crpuc_pkg::CNT_W;
  // Settle count in counter width; the checks below keep the cut lossless
  localparam logic [CW-1:0] PG_LAST = CW'(PG_DELAY);
  localparam logic [CW-1:0] PG_STEP = CW'(1);

  // Zero would report good before the regulator could settle
  if (PG_DELAY < 1) begin : g_pg_delay_low
    $error("PG_DELAY must be at least one cycle");
  end
  // Counter must be able to reach the settle count
  if (PG_DELAY >= (1 << CW)) begin : g_pg_delay_high
    $error("PG_DELAY does not fit the settle counter");
  end
  if (CW < 1 || CW > 16) begin : g_cnt_w_bad
    $error("Settle counter width out of range");
  end

  // Power-good phases after the regulator turns on
  typedef enum logic [1:0] {
    PG_OFF,
    PG_SETTLE,
    PG_GOOD
  } crpuc_pg_phase_t;

  typedef struct packed {
    logic init_done;
    logic init_state;
    logic reg_en;
    crpuc_pg_phase_t pg_phase;
    logic [CW-1:0] pg_cnt;
    logic power_good;
    logic pu_out;
  } crpuc_state_t;

  // Everything off while the 3.3 V supply is still ramping
  localparam crpuc_state_t ST_RESET = '{
    init_done: crpuc_pkg::RST_INIT_DONE,
    init_state: crpuc_pkg::RST_INIT_STATE,
    reg_en: crpuc_pkg::RST_REG_EN,
    pg_phase: PG_OFF,
    pg_cnt: '0,
    power_good: crpuc_pkg::RST_POWER_GOOD,
    pu_out: crpuc_pkg::RST_PU_OUT
  };

  crpuc_state_t st_q;
  crpuc_state_t st_d;
  logic pin_n;
  logic term_pin;
  logic term_test_reset;
  logic term_request;
  logic wake;
  logic rtc_clear;
  logic rtc_seen;

  assign pin_n = i_power_up_pin_n_driven ? i_power_up_pin_n : crpuc_pkg::PIN_PULL_LEVEL;

  assign term_pin = ~pin_n;
  assign term_test_reset = i_test_reset;
  assign term_request = i_core_power_up_request;

  assign wake = term_request | term_pin | term_test_reset;

  // Drop a latched match once no pin, request or test reset holds the regulator on
  assign rtc_clear = st_q.init_done & ~wake;

  crpuc_edge_latch u_rtc (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_level(i_rtc_wake_match),
    .i_clear(rtc_clear),
    .o_seen(rtc_seen)
  );

  always_comb begin
    st_d = st_q;
    if (!st_q.init_done) begin
      st_d.init_done = 1'h1;
      st_d.init_state = REGULATOR_INITIAL_STATE;
    end else if (!i_core_power_up_request) begin
      // Request low withdraws the start-up term for good
      st_d.init_state = 1'h0;
    end
    st_d.reg_en = wake | rtc_seen | st_d.init_state;
    unique case (st_q.pg_phase)
      PG_OFF: begin
        if (st_q.reg_en) begin
          st_d.pg_phase = PG_SETTLE;
          st_d.pg_cnt = PG_STEP;
        end
      end
      PG_SETTLE: begin
        if (st_q.pg_cnt != PG_LAST) begin
          st_d.pg_cnt = st_q.pg_cnt + PG_STEP;
        end else begin
          st_d.pg_phase = PG_GOOD;
          st_d.power_good = 1'h1;
        end
      end
      PG_GOOD: begin
        st_d.power_good = 1'h1;
      end
      default: begin
        st_d.pg_phase = PG_OFF;
      end
    endcase
    // Losing the enable restarts the settle time from zero
    if (!st_q.reg_en) begin
      st_d.pg_phase = PG_OFF;
      st_d.pg_cnt = '0;
      st_d.power_good = 1'h0;
    end
    st_d.pu_out = term_pin;
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q <= ST_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_regulator_enable = st_q.reg_en;
  assign o_core_power_good = st_q.power_good;
  assign o_core_power_up_out = st_q.pu_out;
endmodule

// ### sim/crpuc_monitor.sv
// Purpose: port checks of crpuc_top
// Assumes: one clock domain
// Notes: bound from the bench
`timescale 1ns/100ps
module crpuc_monitor (
  input wire logic i_clk, // in
  input wire logic i_rst_b, // in
  input wire logic i_core_power_up_request, // in
  input wire logic i_power_up_pin_n, // in
  input wire logic i_power_up_pin_n_driven, // in
  input wire logic i_test_reset, // in
  input wire logic i_rtc_wake_match, // in
  input wire logic o_regulator_enable, // in
  input wire logic o_core_power_good, // in
  input wire logic o_core_power_up_out // in
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  wire logic pe = i_power_up_pin_n | !i_power_up_pin_n_driven;
  wire logic quiet = !i_core_power_up_request & pe & !i_test_reset & !i_rtc_wake_match;
  AST_PIN_ON: assert property (!pe |=> o_regulator_enable) else $error("pin");
  AST_TRST_ON: assert property (i_test_reset |=> o_regulator_enable) else $error("trst");
  AST_REQ_ON: assert property (i_core_power_up_request |=> o_regulator_enable) else $error("req");
  AST_OFF: assert property (quiet[*4] |=> !o_regulator_enable) else $error("off");
  AST_RTC_ON: assert property ($rose(i_rtc_wake_match) |-> ##[1:2] o_regulator_enable) else $error("rtc");
  AST_OUT_INV: assert property (1'h1 |=> o_core_power_up_out != $past(pe)) else $error("inv");
  AST_FLOAT: assert property (!i_power_up_pin_n_driven |=> !o_core_power_up_out) else $error("flt");
  AST_GOOD_DROP: assert property (!o_regulator_enable |=> !o_core_power_good) else $error("pg");
endmodule

// ### sim/crpuc_partner.sv
// Purpose: pads, rtc and core logic around crpuc_top
// Assumes: word is req, pad, driven, trst, rtc
// Notes: a floating pad reads high through its pull-up
`timescale 1ns/100ps
module crpuc_partner (
  input wire logic [4:0] i_word, // Wanted levels
  output logic [4:0] o_pins // Pin levels
);
  always_comb begin
    o_pins = {i_word[4], i_word[2] ? i_word[3] : 1'h1, i_word[2:0]};
  end
endmodule

// ### sim/crpuc_tb_top.sv
// Purpose: self-checking bench of crpuc_top
// Assumes: dut starts with the regulator on, dut_cold with it off
// Notes: random pins with a fixed seed
`timescale 1ns/100ps
module crpuc_tb_top;
  logic i_clk = 1'h0;
  logic i_rst_b = 1'h0;
  logic [4:0] word = 5'h0C;
  logic [4:0] p;
  logic en, good, pu;
  logic en_cold;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  always #5 i_clk = !i_clk;
  crpuc_partner u_far (.i_word(word), .o_pins(p));
  crpuc_top #(.REGULATOR_INITIAL_STATE(1'h1), .PG_DELAY(4)) dut (.i_clk, .i_rst_b,
    .i_core_power_up_request(p[4]), .i_power_up_pin_n(p[3]), .i_power_up_pin_n_driven(p[2]),
    .i_test_reset(p[1]), .i_rtc_wake_match(p[0]), .o_regulator_enable(en),
    .o_core_power_good(good), .o_core_power_up_out(pu));
  crpuc_top #(.REGULATOR_INITIAL_STATE(1'h0), .PG_DELAY(4)) dut_cold (.i_clk, .i_rst_b,
    .i_core_power_up_request(p[4]), .i_power_up_pin_n(p[3]), .i_power_up_pin_n_driven(p[2]),
    .i_test_reset(p[1]), .i_rtc_wake_match(p[0]), .o_regulator_enable(en_cold),
    .o_core_power_good(), .o_core_power_up_out());
  function automatic logic forced(input logic [4:0] w);
    return w[4] | (w[2] & !w[3]) | w[1];
  endfunction
  task automatic chk(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %0t got %b", $time, got);
    end
  endtask
  task automatic go(input logic [4:0] w, input int n);
    word = w;
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic close_out;
    if (n_fail == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      close_out;
    end
  end
  initial begin
    logic [4:0] w;
    logic held;
    logic rtc_prev;
    void'($urandom(32'hAA28A433));
    repeat (4) @(posedge i_clk);
    #1 i_rst_b = 1'h1;
    go(5'h0C, 1);
    chk(en, 1'h1);
    chk(en_cold, 1'h0);
    go(5'h0C, 5);
    chk(en, 1'h0);
    go(5'h01, 2);
    chk(en, 1'h1);
    go(5'h0C, 8);
    chk(en, 1'h0);
    go(5'h02, 8);
    chk(good, 1'h1);
    go(5'h0C, 2);
    chk(good, 1'h0);
    // Latched rtc wake, empty after the quiet run above
    held = 1'h0;
    rtc_prev = 1'h0;
    repeat (400) begin
      w = 5'($urandom);
      go(w, 1);
      chk(pu, w[2] & !w[3]);
      chk(en, forced(w) | held);
      held = (w[0] & !rtc_prev) | (held & forced(w));
      rtc_prev = w[0];
    end
    close_out;
  end
endmodule
bind crpuc_top crpuc_monitor u_mon (.i_clk, .i_rst_b, .i_core_power_up_request,
  .i_power_up_pin_n, .i_power_up_pin_n_driven, .i_test_reset, .i_rtc_wake_match,
  .o_regulator_enable, .o_core_power_good, .o_core_power_up_out);
